// ### src/uqk_usart.v
// Asynchronous serial transceiver carrying the revision's documented quirks
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "uqk_regs.vh"
// Notes on behaviour
// R1: Zero guard time: break right after stop bit may miss the break flag.
// R2: Software with one stop bit programs nonzero guard time for reliable breaks.
// R3: Flow control: clear-to-send rising mid-character also sends the holding character.
// R4: Manchester mode is non-functional; no DMA or guard time there.
// R5: Synchronous serial peripheral mode is non-functional; software must not select it.
// R6: Modem mode treats carrier-detect input as asserted when high.
// R7: Smart-card error counter always reads zero.
// R8: Other functions behave as standard start, data, parity, stop asynchronous serial.
module uqk_usart (
    input  wire        clock_in,
    input  wire        rstn_in,
    input  wire [3:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [31:0] rdata_out,
    input  wire        rxd_in,
    output reg         txd_out,
    input  wire        cts_n_in,
    input  wire        carrier_detect_input_in,
    output reg         carrier_out,
    output reg         irq_out
);
    reg  [8:0]  ctrl_q;
    reg  [15:0] baud_q;
    reg  [7:0]  guard_q;
    reg  [7:0]  hold_q;
    reg         hold_full_q;
    reg  [4:0]  irq_stat_q;
    reg  [4:0]  irq_en_q;
    reg  [7:0]  rx_data_q;
    wire [1:0]  mode = ctrl_q[`UQK_CTRL_MODE_HI:`UQK_CTRL_MODE_LO];
    wire        async_ok = (mode == `UQK_MODE_ASYNC);  // [R4] [R5]
    wire        cts_ok = ~ctrl_q[`UQK_CTRL_FLOW] | ~cts_n_in;
    // Transmitter state
    localparam TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3,
               TX_STOP = 3'h4, TX_GUARD = 3'h5;
    reg  [2:0]  tx_st_q;
    reg  [15:0] tx_div_q;
    reg  [2:0]  tx_bit_q;
    reg  [7:0]  tx_sh_q;
    reg  [7:0]  tx_gcnt_q;
    reg         tx_par_q;
    reg         tx_stop2_q;
    reg         cts_n_prev_q;
    reg         cts_rise_q;
    wire        tx_tick = (tx_div_q == 16'h0000);
    wire        tx_load = hold_full_q & ctrl_q[`UQK_CTRL_TXEN] & async_ok;
    // Receiver state
    localparam RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3,
               RX_STOP = 3'h4;
    reg  [2:0]  rx_st_q;
    reg  [15:0] rx_div_q;
    reg  [2:0]  rx_bit_q;
    reg  [7:0]  rx_sh_q;
    reg         rx_par_q;
    reg         rx_brk_q;
    reg         stop_end_q;
    wire        rx_tick = (rx_div_q == 16'h0000);
    wire        wr_data = wr_in & (addr_in == `UQK_OFF_TXDATA);
    wire        rd_rx = rd_in & (addr_in == `UQK_OFF_RXDATA);
    reg  [4:0]  ev;
    // Registers, holding register, interrupt flags; set wins over clear
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q      <= `UQK_CTRL_RESET;
            baud_q      <= `UQK_BAUD_RESET;
            guard_q     <= `UQK_GUARD_RESET;
            hold_q      <= 8'h00;
            hold_full_q <= 1'b0;
            irq_stat_q  <= 5'h00;
            irq_en_q    <= 5'h00;
            rdata_out   <= 32'h0000_0000;
            irq_out     <= 1'b0;
            carrier_out <= 1'b0;
        end else begin
            if (wr_in && addr_in == `UQK_OFF_CTRL)  ctrl_q  <= wdata_in[8:0];
            if (wr_in && addr_in == `UQK_OFF_BAUD)  baud_q  <= wdata_in[15:0];
            if (wr_in && addr_in == `UQK_OFF_GUARD) guard_q <= wdata_in[7:0];
            if (wr_in && addr_in == `UQK_OFF_IRQ_EN) irq_en_q <= wdata_in[4:0];
            if (wr_data) begin
                hold_q      <= wdata_in[7:0];
                hold_full_q <= 1'b1;
            end else if (tx_st_q == TX_IDLE && tx_load && cts_ok) begin
                hold_full_q <= 1'b0;
            end else if (tx_st_q == TX_STOP && tx_tick && !tx_stop2_q &&
                         cts_rise_q && tx_load) begin
                // Must match the engine: the held character leaves only after the last stop
                hold_full_q <= 1'b0;                     // [R3]
            end
            irq_stat_q <= ((wr_in && addr_in == `UQK_OFF_IRQ_CLR) ?
                           (irq_stat_q & ~wdata_in[4:0]) : irq_stat_q) | ev;
            irq_out    <= |(irq_stat_q & irq_en_q);
            carrier_out <= ctrl_q[`UQK_CTRL_MODEM] & carrier_detect_input_in; // [R6]
            rdata_out  <= 32'h0000_0000;
            if (rd_in) begin
                case (addr_in)
                    `UQK_OFF_CTRL:     rdata_out <= {23'h0, ctrl_q};
                    `UQK_OFF_BAUD:     rdata_out <= {16'h0, baud_q};
                    `UQK_OFF_GUARD:    rdata_out <= {24'h0, guard_q};
                    `UQK_OFF_RXDATA:   rdata_out <= {24'h0, rx_data_q};
                    `UQK_OFF_STATUS:   rdata_out <= {29'h0, tx_st_q == TX_IDLE, hold_full_q,
                                                     irq_stat_q[`UQK_IRQ_RXRDY]};
                    `UQK_OFF_IRQ_STAT: rdata_out <= {27'h0, irq_stat_q};
                    `UQK_OFF_IRQ_EN:   rdata_out <= {27'h0, irq_en_q};
                    `UQK_OFF_ERR_CNT:  rdata_out <= 32'h0000_0000; // [R7]
                    default:           rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end
    // Event pulses gathered for the sticky flags
    always @* begin
        ev = 5'h00;
        ev[`UQK_IRQ_RXRDY]   = (rx_st_q == RX_STOP) && rx_tick && rxd_in;
        ev[`UQK_IRQ_BREAK]   = (rx_st_q == RX_STOP) && rx_tick && !rxd_in &&
                               (rx_sh_q == 8'h00) && rx_brk_q;
        ev[`UQK_IRQ_FRAMERR] = (rx_st_q == RX_STOP) && rx_tick && !rxd_in;
        ev[`UQK_IRQ_PARERR]  = (rx_st_q == RX_PAR) && rx_tick &&
                               (rxd_in != (rx_par_q ^ ctrl_q[`UQK_CTRL_PARODD]));
        ev[`UQK_IRQ_TXEMPTY] = wr_data ? 1'b0 : (tx_st_q == TX_IDLE) && !hold_full_q &&
                               (tx_div_q == 16'h0001);
    end
    // Transmit engine; guard time idles the line after each character, except one chained by a clear-to-send rise
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_st_q      <= TX_IDLE;
            tx_div_q     <= 16'h0000;
            tx_bit_q     <= 3'h0;
            tx_sh_q      <= 8'h00;
            tx_gcnt_q    <= 8'h00;
            tx_par_q     <= 1'b0;
            tx_stop2_q   <= 1'b0;
            txd_out      <= 1'b1;
            cts_n_prev_q <= 1'b1;
            cts_rise_q   <= 1'b0;
        end else begin
            cts_n_prev_q <= cts_n_in;
            // A rising clear-to-send mid-character lets the next one go regardless
            if (tx_st_q == TX_IDLE)
                cts_rise_q <= 1'b0;
            else if (ctrl_q[`UQK_CTRL_FLOW] && !cts_n_prev_q && cts_n_in)
                cts_rise_q <= 1'b1;                      // [R3]
            tx_div_q <= tx_tick ? baud_q : tx_div_q - 16'h0001;
            case (tx_st_q)
                TX_IDLE: begin
                    txd_out <= 1'b1;
                    if (tx_load && cts_ok) begin         // [R8]
                        tx_sh_q  <= hold_q;
                        tx_par_q <= ^hold_q;
                        tx_st_q  <= TX_START;
                        tx_div_q <= baud_q;
                        txd_out  <= 1'b0;
                    end
                end
                TX_START: if (tx_tick) begin
                    txd_out  <= tx_sh_q[0];
                    tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                    tx_bit_q <= 3'h0;
                    tx_st_q  <= TX_DATA;
                end
                TX_DATA: if (tx_tick) begin
                    tx_bit_q <= tx_bit_q + 3'h1;
                    if (tx_bit_q == 3'h7) begin
                        tx_stop2_q <= ctrl_q[`UQK_CTRL_STOP2];
                        if (ctrl_q[`UQK_CTRL_PAREN]) begin
                            txd_out <= tx_par_q ^ ctrl_q[`UQK_CTRL_PARODD];
                            tx_st_q <= TX_PAR;
                        end else begin
                            txd_out <= 1'b1;
                            tx_st_q <= TX_STOP;
                        end
                    end else begin
                        txd_out <= tx_sh_q[0];
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                    end
                end
                TX_PAR: if (tx_tick) begin
                    txd_out <= 1'b1;
                    tx_st_q <= TX_STOP;
                end
                TX_STOP: if (tx_tick) begin
                    if (tx_stop2_q) begin
                        tx_stop2_q <= 1'b0;
                    end else if (cts_rise_q && tx_load) begin
                        cts_rise_q <= 1'b0;              // One rise lets one character go
                        tx_sh_q  <= hold_q;              // [R3]
                        tx_par_q <= ^hold_q;
                        txd_out  <= 1'b0;
                        tx_st_q  <= TX_START;
                    end else begin
                        tx_gcnt_q <= guard_q;
                        tx_st_q   <= TX_GUARD;
                    end
                end
                TX_GUARD: if (tx_tick) begin
                    if (tx_gcnt_q == 8'h00)
                        tx_st_q <= TX_IDLE;
                    else
                        tx_gcnt_q <= tx_gcnt_q - 8'h01;
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end
    // Receive engine; with zero guard the break qualifier is lost after a stop bit
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_st_q    <= RX_IDLE;
            rx_div_q   <= 16'h0000;
            rx_bit_q   <= 3'h0;
            rx_sh_q    <= 8'h00;
            rx_par_q   <= 1'b0;
            rx_brk_q   <= 1'b0;
            rx_data_q  <= 8'h00;
            stop_end_q <= 1'b0;
        end else begin
            rx_div_q <= rx_tick ? baud_q : rx_div_q - 16'h0001;
            case (rx_st_q)
                RX_IDLE: begin
                    if (!rxd_in && ctrl_q[`UQK_CTRL_RXEN] && async_ok) begin
                        rx_div_q <= {1'b0, baud_q[15:1]};
                        rx_st_q  <= RX_START;
                        // A start directly after a stop with zero guard drops break
                        rx_brk_q <= !(stop_end_q && guard_q == 8'h00); // [R1] [R2]
                        stop_end_q <= 1'b0;
                    end else if (rx_tick) begin
                        // Marker lives one bit time, so a start right behind the stop sees it
                        stop_end_q <= 1'b0;
                    end
                end
                RX_START: if (rx_tick) begin
                    rx_bit_q <= 3'h0;
                    rx_par_q <= 1'b0;
                    rx_st_q  <= rxd_in ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_tick) begin
                    rx_sh_q  <= {rxd_in, rx_sh_q[7:1]};
                    rx_par_q <= rx_par_q ^ rxd_in;
                    rx_bit_q <= rx_bit_q + 3'h1;
                    if (rx_bit_q == 3'h7)
                        rx_st_q <= ctrl_q[`UQK_CTRL_PAREN] ? RX_PAR : RX_STOP;
                end
                RX_PAR: if (rx_tick) rx_st_q <= RX_STOP;
                RX_STOP: if (rx_tick) begin
                    if (rxd_in) rx_data_q <= rx_sh_q;    // [R8]
                    stop_end_q <= rxd_in;
                    rx_st_q    <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end
endmodule // uqk_usart
`default_nettype wire

// ### src/uqk_regs.vh
// Register offsets, field positions, reset values and timing counts of the transceiver
`ifndef UQK_REGS_VH
`define UQK_REGS_VH
`define UQK_ADDR_W        4
`define UQK_OFF_CTRL      4'h0
`define UQK_OFF_BAUD      4'h1
`define UQK_OFF_GUARD     4'h2
`define UQK_OFF_TXDATA    4'h3
`define UQK_OFF_RXDATA    4'h4
`define UQK_OFF_STATUS    4'h5
`define UQK_OFF_IRQ_STAT  4'h6
`define UQK_OFF_IRQ_EN    4'h7
`define UQK_OFF_IRQ_CLR   4'h8
`define UQK_OFF_ERR_CNT   4'h9
// Control register fields
`define UQK_CTRL_TXEN     0
`define UQK_CTRL_RXEN     1
`define UQK_CTRL_PAREN    2
`define UQK_CTRL_PARODD   3
`define UQK_CTRL_STOP2    4
`define UQK_CTRL_FLOW     5
`define UQK_CTRL_MODEM    6
`define UQK_CTRL_MODE_LO  7
`define UQK_CTRL_MODE_HI  8
`define UQK_CTRL_RESET    9'h000
`define UQK_MODE_ASYNC    2'h0
`define UQK_MODE_MANCH    2'h1
`define UQK_MODE_SPI      2'h2
// Interrupt status bits
`define UQK_IRQ_RXRDY     0
`define UQK_IRQ_TXEMPTY   1
`define UQK_IRQ_BREAK     2
`define UQK_IRQ_PARERR    3
`define UQK_IRQ_FRAMERR   4
`define UQK_IRQ_W         5
`define UQK_BAUD_RESET    16'h0015
`define UQK_GUARD_RESET   8'h00
`endif

// ### testbench/uqk_usart_chk.sv
// Port-level assertions for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "uqk_regs.vh"
module uqk_usart_chk (
    input wire logic        clock_in,
    input wire logic        rstn_in,
    input wire logic [3:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        rxd_in,
    input wire logic        txd_out,
    input wire logic        cts_n_in,
    input wire logic        carrier_detect_input_in,
    input wire logic        carrier_out,
    input wire logic        irq_out
);
    // Reset divider gives 22 cycles a bit; the bench keeps it, so bit edges are fixed
    localparam int BIT_CYC = 22;
    logic [15:0] low_run_q;
    // Length of the present low stretch on the transmit line
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in)
            low_run_q <= 16'h0000;
        else
            low_run_q <= txd_out ? 16'h0000 : low_run_q + 16'h0001;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data not zero outside an answer");
    err_count_a: assert property (rd_in && addr_in == `UQK_OFF_ERR_CNT |=> rdata_out == 32'h0)
        else $error("error counter read not zero");
    unmapped_read_a: assert property (rd_in && addr_in > `UQK_OFF_ERR_CNT |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    carrier_low_a: assert property (!carrier_detect_input_in |=> !carrier_out)
        else $error("carrier shown while input low");
    carrier_rise_a: assert property ($rose(carrier_out) |-> $past(carrier_detect_input_in))
        else $error("carrier rose without high input");
    tx_reset_idle_a: assert property ($rose(rstn_in) |-> txd_out && !irq_out && !carrier_out)
        else $error("outputs not idle after reset");
    bit_time_a: assert property ($rose(txd_out) |-> low_run_q != 16'h0 && low_run_q % BIT_CYC == 0)
        else $error("low stretch not whole bit times");
    irq_mask_a: assert property (wr_in && addr_in == `UQK_OFF_IRQ_EN && wdata_in[4:0] == 5'h0
        |-> ##2 !irq_out)
        else $error("interrupt high with all enables off");
    cover property (rd_in && addr_in == `UQK_OFF_ERR_CNT);
    cover property ($rose(irq_out));
    cover property ($rose(carrier_out));
endmodule // uqk_usart_chk
bind uqk_usart uqk_usart_chk CHK (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd_in),
    .txd_out(txd_out), .cts_n_in(cts_n_in), .carrier_detect_input_in(carrier_detect_input_in),
    .carrier_out(carrier_out), .irq_out(irq_out));
`default_nettype wire

// ### testbench/uqk_term.sv
// Remote serial terminal model: sends frames and collects transmitted characters
`timescale 1ns/1ps
`default_nettype none
module uqk_term #(
    parameter int BIT_CYC = 22
) (
    input  wire logic clock_in,
    input  wire logic txd_in,
    output var  logic rxd_out
);
    logic [7:0] got_q[$];
    initial rxd_out = 1'b1;
    // Start, eight bits LSB first, stop; a low stop with zero data is a break
    task automatic send(input logic [7:0] b, input logic stop_v);
        logic [9:0] f;
        f = {stop_v, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock_in);
            rxd_out <= f[i];
            repeat (BIT_CYC - 1) @(posedge clock_in);
        end
        // Stop ends exactly here, so a following frame comes with no idle gap
        if (!stop_v) begin
            @(posedge clock_in);
            rxd_out <= 1'b1;
        end
    endtask
    // Capture: find the start edge, sample each bit at its middle
    initial forever begin
        logic [7:0] c;
        @(negedge txd_in);
        repeat (BIT_CYC / 2) @(posedge clock_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clock_in);
            c[i] = txd_in;
        end
        repeat (BIT_CYC) @(posedge clock_in);
        got_q.push_back(c);
    end
endmodule // uqk_term
`default_nettype wire

// ### testbench/usart_revision_quirks_bench.sv
// Self-checking bench: registers, frames, flow control and the revision quirks
`timescale 1ns/1ps
`default_nettype none
`include "uqk_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module usart_revision_quirks_bench;
    logic        clock_in, rstn_in, wr_in, rd_in, cts_n_in, carrier_in;
    logic        rxd, txd_out, carrier_out, irq_out;
    logic [3:0]  addr_in;
    logic [31:0] wdata_in, rdata_out;
    int          err_total, compares;
    uqk_usart DUT (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .rxd_in(rxd), .txd_out(txd_out), .cts_n_in(cts_n_in),
        .carrier_detect_input_in(carrier_in), .carrier_out(carrier_out), .irq_out(irq_out));
    uqk_term TERM (.clock_in(clock_in), .txd_in(txd_out), .rxd_out(rxd));
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    // Read answer stands only in the cycle after the strobe, so sample it there
    task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        `CHK(rdata_out & m, e)
    endtask
    // Bounded wait: interrupt when n is 0, else n captured characters
    task automatic wait_ev(input int n);
        int i;
        for (i = 0; i < 4000; i++) begin
            if (n == 0 ? irq_out === 1'b1 : TERM.got_q.size() >= n)
                break;
            @(posedge clock_in);
        end
        if (i == 4000) begin
            err_total++;
            final_report();
        end
    endtask
    initial begin
        {rstn_in, wr_in, rd_in, cts_n_in, carrier_in} = 5'h00;
        addr_in = 4'h0;
        wdata_in = 32'h0;
        repeat (5) @(posedge clock_in);
        rstn_in <= 1'b1;
        rdc(`UQK_OFF_BAUD, 32'hffffffff, 32'h15);
        rdc(`UQK_OFF_CTRL, 32'hffffffff, 32'h0);
        rdc(`UQK_OFF_ERR_CNT, 32'hffffffff, 32'h0);
        rdc(4'hf, 32'hffffffff, 32'h0);
        $display("register reset test done");
        wr(`UQK_OFF_GUARD, 32'h1);
        wr(`UQK_OFF_CTRL, 32'h3);
        wr(`UQK_OFF_IRQ_EN, 32'h1);
        TERM.send(8'ha5, 1'b1);
        wait_ev(0);
        rdc(`UQK_OFF_RXDATA, 32'hff, 32'ha5);
        wr(`UQK_OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge clock_in);
        #1 `CHK(irq_out, 1'b0)
        rdc(`UQK_OFF_IRQ_STAT, 32'h1, 32'h1);
        wr(`UQK_OFF_IRQ_CLR, 32'h1f);
        rdc(`UQK_OFF_IRQ_STAT, 32'h1, 32'h0);
        $display("receive and interrupt test done");
        wr(`UQK_OFF_IRQ_EN, 32'h4);
        TERM.send(8'h00, 1'b0);
        wait_ev(0);
        rdc(`UQK_OFF_IRQ_STAT, 32'h4, 32'h4);
        rdc(`UQK_OFF_IRQ_STAT, 32'h10, 32'h10);
        wr(`UQK_OFF_IRQ_CLR, 32'h1f);
        wr(`UQK_OFF_GUARD, 32'h0);
        TERM.send(8'h5a, 1'b1);
        TERM.send(8'h00, 1'b0);
        repeat (60) @(posedge clock_in);
        rdc(`UQK_OFF_IRQ_STAT, 32'h4, 32'h0);
        $display("break test done");
        // Even parity: the high bit after the data lands in the parity slot
        wr(`UQK_OFF_CTRL, 32'h7);
        wr(`UQK_OFF_IRQ_CLR, 32'h1f);
        TERM.send(8'h03, 1'b1);
        repeat (40) @(posedge clock_in);
        rdc(`UQK_OFF_IRQ_STAT, 32'ha, 32'ha);
        wr(`UQK_OFF_IRQ_CLR, 32'h1f);
        TERM.send(8'h01, 1'b1);
        repeat (40) @(posedge clock_in);
        rdc(`UQK_OFF_IRQ_STAT, 32'h8, 32'h0);
        wr(`UQK_OFF_CTRL, 32'h3);
        $display("parity test done");
        wr(`UQK_OFF_TXDATA, 32'h3c);
        wait_ev(1);
        `CHK(TERM.got_q[0], 8'h3c)
        // Let the stop and guard end, so the first flow character starts at once
        repeat (60) @(posedge clock_in);
        wr(`UQK_OFF_CTRL, 32'h23);
        wr(`UQK_OFF_TXDATA, 32'h11);
        wr(`UQK_OFF_TXDATA, 32'h22);
        repeat (60) @(posedge clock_in);
        cts_n_in <= 1'b1;
        wait_ev(3);
        `CHK(TERM.got_q[2], 8'h22)
        wr(`UQK_OFF_TXDATA, 32'h33);
        repeat (600) @(posedge clock_in);
        `CHK(TERM.got_q.size(), 3)
        cts_n_in <= 1'b0;
        wait_ev(4);
        `CHK(TERM.got_q[3], 8'h33)
        $display("transmit and flow test done");
        wr(`UQK_OFF_CTRL, 32'h40);
        for (int k = 0; k < 3; k++) begin
            @(posedge clock_in);
            carrier_in <= k[0];
            repeat (2) @(posedge clock_in);
            #1 `CHK(carrier_out, k[0])
        end
        $display("carrier test done");
        // Both broken modes must leave the line idle with a character waiting
        for (int m = 1; m < 3; m++) begin
            wr(`UQK_OFF_CTRL, (m << 7) | 3);
            wr(`UQK_OFF_TXDATA, 32'h55);
            repeat (300) @(posedge clock_in);
            `CHK(TERM.got_q.size(), 4)
        end
        rdc(`UQK_OFF_STATUS, 32'h6, 32'h6);
        $display("disabled mode test done");
        final_report();
    end
endmodule // usart_revision_quirks_bench
`default_nettype wire
